// file: include/cfgj_defines.svh
// constants of the configuration device test access port
`ifndef CFGJ_DEFINES_SVH
`define CFGJ_DEFINES_SVH

// register lengths
`define CFGJ_IR_LEN 10
`define CFGJ_BSR_LEN 174
`define CFGJ_DR32_LEN 32

// instruction opcodes
`define CFGJ_OP_SAMPLE 10'h055
`define CFGJ_OP_EXTEST 10'h000
`define CFGJ_OP_BYPASS 10'h3ff
`define CFGJ_OP_IDCODE 10'h059
`define CFGJ_OP_USERCODE 10'h079
`define CFGJ_OP_INIT_CONFIG 10'h061
`define CFGJ_OP_HOLD_CONFIG_INSTRUCTION 10'h065

// value loaded into the instruction shifter at capture
`define CFGJ_IR_CAPTURE 10'h001

`endif

// file: include/cfgj_pkg.sv
// types shared by the test access port design
`include "cfgj_defines.svh"

package cfgj_pkg;

    // tap controller states
    typedef enum logic [3:0] {
        ST_TLR = 4'h0,
        ST_RTI = 4'h1,
        ST_SEL_DR = 4'h2,
        ST_CAP_DR = 4'h3,
        ST_SH_DR = 4'h4,
        ST_EX1_DR = 4'h5,
        ST_PA_DR = 4'h6,
        ST_EX2_DR = 4'h7,
        ST_UPD_DR = 4'h8,
        ST_SEL_IR = 4'h9,
        ST_CAP_IR = 4'ha,
        ST_SH_IR = 4'hb,
        ST_EX1_IR = 4'hc,
        ST_PA_IR = 4'hd,
        ST_EX2_IR = 4'he,
        ST_UPD_IR = 4'hf
    } cfgj_tap_state_t;

    // decoded instructions
    typedef enum logic [2:0] {
        IN_EXTEST = 3'h0,
        IN_SAMPLE = 3'h1,
        IN_BYPASS = 3'h2,
        IN_IDCODE = 3'h3,
        IN_USERCODE = 3'h4,
        IN_INIT_CONFIG = 3'h5,
        IN_HOLD_CONFIG = 3'h6
    } cfgj_instr_t;

    // boundary cell control toward the pins
    typedef struct packed {
        logic extest;
        logic [`CFGJ_BSR_LEN-1:0] drive;
    } cfgj_bs_ctl_t;

    // levels captured from outside the tck domain
    typedef struct packed {
        logic [`CFGJ_DR32_LEN-1:0] usercode;
        logic [`CFGJ_BSR_LEN-1:0] pins;
    } cfgj_cap_t;

endpackage

// file: src/cfgj_sync.sv
// two flip-flop level synchroniser
module cfgj_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_q; // first stage, read only by second

    // two stages, cleared to zero on reset
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= '0;
            q <= '0;
        end else begin
            meta_q <= d;
            q <= meta_q;
        end
    end
endmodule // cfgj_sync

// file: src/cfgj_tap_fsm.sv
// sixteen state tap controller stepped by tms
module cfgj_tap_fsm (
    input wire logic tck,
    input wire logic rst_n,
    input wire logic tms,
    output cfgj_pkg::cfgj_tap_state_t state
);
    import cfgj_pkg::*;

    cfgj_tap_state_t state_q; // current state
    cfgj_tap_state_t state_d; // next state

    // next state from tms
    always_comb begin
        case (state_q)
            ST_TLR: state_d = tms ? ST_TLR : ST_RTI;
            ST_RTI: state_d = tms ? ST_SEL_DR : ST_RTI;
            ST_SEL_DR: state_d = tms ? ST_SEL_IR : ST_CAP_DR;
            ST_CAP_DR: state_d = tms ? ST_EX1_DR : ST_SH_DR;
            ST_SH_DR: state_d = tms ? ST_EX1_DR : ST_SH_DR;
            ST_EX1_DR: state_d = tms ? ST_UPD_DR : ST_PA_DR;
            ST_PA_DR: state_d = tms ? ST_EX2_DR : ST_PA_DR;
            ST_EX2_DR: state_d = tms ? ST_UPD_DR : ST_SH_DR;
            ST_UPD_DR: state_d = tms ? ST_SEL_DR : ST_RTI;
            ST_SEL_IR: state_d = tms ? ST_TLR : ST_CAP_IR;
            ST_CAP_IR: state_d = tms ? ST_EX1_IR : ST_SH_IR;
            ST_SH_IR: state_d = tms ? ST_EX1_IR : ST_SH_IR;
            ST_EX1_IR: state_d = tms ? ST_UPD_IR : ST_PA_IR;
            ST_PA_IR: state_d = tms ? ST_EX2_IR : ST_PA_IR;
            ST_EX2_IR: state_d = tms ? ST_UPD_IR : ST_SH_IR;
            ST_UPD_IR: state_d = tms ? ST_SEL_DR : ST_RTI;
            default: state_d = ST_TLR;
        endcase
    end

    // state register, reset into test logic reset
    always_ff @(posedge tck or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= ST_TLR;
        end else begin
            state_q <= state_d;
        end
    end

    assign state = state_q;
endmodule // cfgj_tap_fsm

// file: src/cfgj_tap_top.sv
// test access port of the configuration device with reconfiguration pin
// Behaviour
// [RQ1] instruction register is exactly ten bits
// [RQ2] boundary chain of 174 cells
// [RQ3] opcode 055 selects sample/preload
// [RQ4] opcode 000 selects extest driving pins
// [RQ5] opcode 3ff selects one-bit bypass
// [RQ6] opcode 059 shifts fixed identification word
// [RQ7] opcode 079 shifts 32-bit stored usercode
// [RQ8] opcode 061 drives reconfig low in idle
// [RQ9] release reconfig pin on leaving idle
// [RQ10] opcode 065 holds reconfig pin low
// [RQ11] hold lasts until reconfigure instruction issued
// [RQ12] outside master tristates flash bus first
// [RQ13] programming uses the four tap signals
// [RQ14] controller waits for power-on reset end
// [RQ15] boundary tests only outside configuration
// [RQ16] unknown opcodes select the bypass bit
`include "cfgj_defines.svh"
module cfgj_tap_top #(
    parameter logic [31:0] ID_VALUE = 32'h0a5a_5a5b // arbitrary value
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    output logic tdo,
    output logic tdo_oe,
    input wire logic [`CFGJ_BSR_LEN-1:0] pin_lvl,
    input wire logic [`CFGJ_DR32_LEN-1:0] usercode_nv,
    output cfgj_pkg::cfgj_bs_ctl_t bs_ctl,
    input wire logic reconf_pin,
    output logic reconf_drv,
    output logic reconf_oe,
    output logic reconf_low
);
    import cfgj_pkg::*;

    // tck domain state
    cfgj_tap_state_t state; // controller state
    cfgj_cap_t cap_raw; // levels before synchronising
    cfgj_cap_t cap_s; // levels synchronised to tck
    logic [`CFGJ_IR_LEN-1:0] ir_sh_q, ir_sh_d; // instruction shifter
    logic [`CFGJ_IR_LEN-1:0] ir_q, ir_d; // active opcode
    cfgj_instr_t instr_q, instr_d; // decoded active instruction
    logic byp_q, byp_d; // one-bit bypass
    logic [`CFGJ_DR32_LEN-1:0] dr32_q, dr32_d; // id and usercode shifter
    logic [`CFGJ_BSR_LEN-1:0] bsr_sh_q, bsr_sh_d; // boundary shift stage
    cfgj_bs_ctl_t bs_q, bs_d; // boundary update stage
    logic hold_q, hold_d; // hold instruction latched
    logic drive_q, drive_d; // want reconfig pin low
    logic tdo_q, tdo_d; // serial out, falling edge
    logic tdo_oe_q, tdo_oe_d; // out enable, falling edge

    // clk domain state
    logic [1:0] clk_s; // {drive, pin low} synchronised
    logic oe_q, oe_d; // open drain enable
    logic low_q, low_d; // observed pin level low

    // opcode to instruction, unknown codes fall to bypass
    function automatic cfgj_instr_t cfgj_decode(input logic [`CFGJ_IR_LEN-1:0] op);
        case (op)
            `CFGJ_OP_SAMPLE: cfgj_decode = IN_SAMPLE; // see [RQ3]
            `CFGJ_OP_EXTEST: cfgj_decode = IN_EXTEST; // see [RQ4]
            `CFGJ_OP_IDCODE: cfgj_decode = IN_IDCODE; // see [RQ6]
            `CFGJ_OP_USERCODE: cfgj_decode = IN_USERCODE; // see [RQ7]
            `CFGJ_OP_INIT_CONFIG: cfgj_decode = IN_INIT_CONFIG; // see [RQ8]
            `CFGJ_OP_HOLD_CONFIG_INSTRUCTION: cfgj_decode = IN_HOLD_CONFIG; // see [RQ10]
            default: cfgj_decode = IN_BYPASS; // see [RQ5] see [RQ16]
        endcase
    endfunction

    // instructions that place the bypass bit in the chain
    function automatic logic cfgj_is_byp(input cfgj_instr_t ins);
        cfgj_is_byp = (ins == IN_BYPASS) || (ins == IN_INIT_CONFIG)
            || (ins == IN_HOLD_CONFIG);
    endfunction

    // instructions that use the boundary chain
    function automatic logic cfgj_is_bs(input cfgj_instr_t ins);
        cfgj_is_bs = (ins == IN_SAMPLE) || (ins == IN_EXTEST);
    endfunction

    // controller driven by tms on tck
    cfgj_tap_fsm u_fsm (
        .tck(tck),
        .rst_n(rst_n),
        .tms(tms),
        .state(state)
    ); // see [RQ13]

    // pins and stored usercode come from outside tck
    assign cap_raw.pins = pin_lvl;
    assign cap_raw.usercode = usercode_nv;

    cfgj_sync #(
        .W(`CFGJ_BSR_LEN + `CFGJ_DR32_LEN)
    ) u_cap_sync (
        .clk(tck),
        .rst_n(rst_n),
        .d(cap_raw),
        .q(cap_s)
    );

    // next values of instruction and data registers
    always_comb begin
        ir_sh_d = ir_sh_q;
        ir_d = ir_q;
        instr_d = instr_q;
        byp_d = byp_q;
        dr32_d = dr32_q;
        bsr_sh_d = bsr_sh_q;
        bs_d = bs_q;
        hold_d = hold_q;
        case (state)
            // reset selects identification, pins back to system
            ST_TLR: begin
                ir_d = `CFGJ_OP_IDCODE;
                instr_d = IN_IDCODE;
                bs_d.extest = 1'b0;
            end
            // fixed pattern into ten-bit shifter
            ST_CAP_IR: begin
                ir_sh_d = `CFGJ_IR_CAPTURE; // see [RQ1]
            end
            ST_SH_IR: begin
                ir_sh_d = {tdi, ir_sh_q[`CFGJ_IR_LEN-1:1]}; // see [RQ1]
            end
            // new instruction takes effect
            ST_UPD_IR: begin
                ir_d = ir_sh_q;
                instr_d = cfgj_decode(ir_sh_q); // see [RQ16]
                bs_d.extest = (cfgj_decode(ir_sh_q) == IN_EXTEST); // see [RQ4]
                if (cfgj_decode(ir_sh_q) == IN_HOLD_CONFIG) begin
                    hold_d = 1'b1; // see [RQ10]
                end else if (cfgj_decode(ir_sh_q) == IN_INIT_CONFIG) begin
                    hold_d = 1'b0; // see [RQ11]
                end
            end
            // load selected data register
            ST_CAP_DR: begin
                if (cfgj_is_byp(instr_q)) begin
                    byp_d = 1'b0; // see [RQ5]
                end else if (instr_q == IN_IDCODE) begin
                    dr32_d = ID_VALUE; // see [RQ6]
                end else if (instr_q == IN_USERCODE) begin
                    dr32_d = cap_s.usercode; // see [RQ7]
                end else begin
                    bsr_sh_d = cap_s.pins; // see [RQ3] see [RQ4]
                end
            end
            // shift selected data register toward tdo
            ST_SH_DR: begin
                if (cfgj_is_byp(instr_q)) begin
                    byp_d = tdi; // see [RQ5]
                end else if (cfgj_is_bs(instr_q)) begin
                    bsr_sh_d = {tdi, bsr_sh_q[`CFGJ_BSR_LEN-1:1]}; // see [RQ2]
                end else begin
                    dr32_d = {tdi, dr32_q[`CFGJ_DR32_LEN-1:1]}; // see [RQ6] see [RQ7]
                end
            end
            // preload or extest pattern to the pins
            ST_UPD_DR: begin
                if (cfgj_is_bs(instr_q)) begin
                    bs_d.drive = bsr_sh_q; // see [RQ3] see [RQ4]
                end
            end
            default: begin
            end
        endcase
        // reconfig pin low while idle under reconfigure, or while held
        drive_d = hold_q
            || ((instr_q == IN_INIT_CONFIG) && (state == ST_RTI)); // see [RQ8] see [RQ9]
    end

    // tck domain registers
    always_ff @(posedge tck or negedge rst_n) begin
        if (!rst_n) begin
            ir_sh_q <= `CFGJ_IR_CAPTURE;
            ir_q <= `CFGJ_OP_IDCODE;
            instr_q <= IN_IDCODE;
            byp_q <= 1'b0;
            dr32_q <= '0;
            bsr_sh_q <= '0;
            bs_q <= '0;
            hold_q <= 1'b0;
            drive_q <= 1'b0;
        end else begin
            ir_sh_q <= ir_sh_d;
            ir_q <= ir_d;
            instr_q <= instr_d;
            byp_q <= byp_d;
            dr32_q <= dr32_d;
            bsr_sh_q <= bsr_sh_d;
            bs_q <= bs_d;
            hold_q <= hold_d;
            drive_q <= drive_d;
        end
    end

    // serial output source for the shift states
    always_comb begin
        tdo_d = 1'b0;
        tdo_oe_d = 1'b0;
        if (state == ST_SH_IR) begin
            tdo_d = ir_sh_q[0];
            tdo_oe_d = 1'b1;
        end else if (state == ST_SH_DR) begin
            tdo_oe_d = 1'b1;
            if (cfgj_is_byp(instr_q)) begin
                tdo_d = byp_q; // see [RQ5]
            end else if (cfgj_is_bs(instr_q)) begin
                tdo_d = bsr_sh_q[0]; // see [RQ2]
            end else begin
                tdo_d = dr32_q[0];
            end
        end
    end

    // tdo changes on the falling edge of tck
    always_ff @(negedge tck or negedge rst_n) begin
        if (!rst_n) begin
            tdo_q <= 1'b0;
            tdo_oe_q <= 1'b0;
        end else begin
            tdo_q <= tdo_d;
            tdo_oe_q <= tdo_oe_d;
        end
    end

    assign tdo = tdo_q;
    assign tdo_oe = tdo_oe_q;
    assign bs_ctl = bs_q;

    // drive request and pin level brought into clk
    cfgj_sync #(
        .W(2)
    ) u_clk_sync (
        .clk(clk),
        .rst_n(rst_n),
        .d({drive_q, ~reconf_pin}),
        .q(clk_s)
    );

    // open drain enable and pin status in clk domain
    always_comb begin
        oe_d = clk_s[1]; // see [RQ8] see [RQ9] see [RQ10]
        low_d = clk_s[0];
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            oe_q <= 1'b0;
            low_q <= 1'b0;
        end else begin
            oe_q <= oe_d;
            low_q <= low_d;
        end
    end

    // pin only ever pulled low, released otherwise
    assign reconf_drv = 1'b0;
    assign reconf_oe = oe_q;
    assign reconf_low = low_q;

    // checks in the tck domain
    property p_ir_capture;
        @(posedge tck) disable iff (!rst_n)
        (state == ST_CAP_IR) |=> (ir_sh_q == `CFGJ_IR_CAPTURE);
    endproperty
    a_ir_capture: assert property (p_ir_capture) // see [RQ1]
        else $error("instruction shifter not loaded with capture value");

    property p_ir_update;
        @(posedge tck) disable iff (!rst_n)
        (state == ST_UPD_IR) |=> (ir_q == $past(ir_sh_q));
    endproperty
    a_ir_update: assert property (p_ir_update) // see [RQ1]
        else $error("active opcode not taken from the shifter");

    property p_bsr_shift;
        @(posedge tck) disable iff (!rst_n)
        (state == ST_SH_DR && cfgj_is_bs(instr_q)) |=>
            (bsr_sh_q[`CFGJ_BSR_LEN-1] == $past(tdi))
            && (bsr_sh_q[`CFGJ_BSR_LEN-2:0] == $past(bsr_sh_q[`CFGJ_BSR_LEN-1:1]));
    endproperty
    a_bsr_shift: assert property (p_bsr_shift) // see [RQ2]
        else $error("boundary chain did not shift by one cell");

    property p_bs_capture;
        @(posedge tck) disable iff (!rst_n)
        (state == ST_CAP_DR && cfgj_is_bs(instr_q)) |=> (bsr_sh_q == $past(cap_s.pins));
    endproperty
    a_bs_capture: assert property (p_bs_capture) // see [RQ3]
        else $error("boundary chain did not capture pin levels");

    property p_extest_mode;
        @(posedge tck) disable iff (!rst_n)
        (state == ST_UPD_IR) |=> (bs_q.extest == (instr_q == IN_EXTEST));
    endproperty
    a_extest_mode: assert property (p_extest_mode) // see [RQ4]
        else $error("extest mode does not follow the instruction");

    property p_bypass_delay;
        @(posedge tck) disable iff (!rst_n)
        (state == ST_SH_DR && cfgj_is_byp(instr_q)) |=> (byp_q == $past(tdi));
    endproperty
    a_bypass_delay: assert property (p_bypass_delay) // see [RQ5]
        else $error("bypass bit did not take tdi");

    property p_idcode_load;
        @(posedge tck) disable iff (!rst_n)
        (state == ST_CAP_DR && instr_q == IN_IDCODE) |=> (dr32_q == ID_VALUE);
    endproperty
    a_idcode_load: assert property (p_idcode_load) // see [RQ6]
        else $error("identification word not captured");

    property p_usercode_load;
        @(posedge tck) disable iff (!rst_n)
        (state == ST_CAP_DR && instr_q == IN_USERCODE) |=> (dr32_q == $past(cap_s.usercode));
    endproperty
    a_usercode_load: assert property (p_usercode_load) // see [RQ7]
        else $error("usercode not captured");

    property p_reconf_low;
        @(posedge tck) disable iff (!rst_n)
        (state == ST_RTI && instr_q == IN_INIT_CONFIG) |=> drive_q;
    endproperty
    a_reconf_low: assert property (p_reconf_low) // see [RQ8]
        else $error("reconfig pin not driven low in idle");

    property p_reconf_release;
        @(posedge tck) disable iff (!rst_n)
        (state != ST_RTI && !hold_q) |=> !drive_q;
    endproperty
    a_reconf_release: assert property (p_reconf_release) // see [RQ9]
        else $error("reconfig pin still driven after leaving idle");

    property p_hold_low;
        @(posedge tck) disable iff (!rst_n)
        (state == ST_UPD_IR && cfgj_decode(ir_sh_q) == IN_HOLD_CONFIG) |=> hold_q ##1 drive_q;
    endproperty
    a_hold_low: assert property (p_hold_low) // see [RQ10]
        else $error("hold instruction did not hold the pin low");

    property p_hold_keep;
        @(posedge tck) disable iff (!rst_n)
        (hold_q && !(state == ST_UPD_IR && cfgj_decode(ir_sh_q) == IN_INIT_CONFIG))
            |=> hold_q;
    endproperty
    a_hold_keep: assert property (p_hold_keep) // see [RQ11]
        else $error("hold dropped without reconfigure instruction");

    property p_unknown_bypass;
        @(posedge tck) disable iff (!rst_n)
        (state == ST_UPD_IR && !(ir_sh_q inside {`CFGJ_OP_SAMPLE, `CFGJ_OP_EXTEST,
            `CFGJ_OP_IDCODE, `CFGJ_OP_USERCODE, `CFGJ_OP_INIT_CONFIG,
            `CFGJ_OP_HOLD_CONFIG_INSTRUCTION})) |=> (instr_q == IN_BYPASS);
    endproperty
    a_unknown_bypass: assert property (p_unknown_bypass) // see [RQ16]
        else $error("unassigned opcode did not select bypass");
endmodule // cfgj_tap_top

// file: verification/cfgj_jtag_host.sv
// behavioural model of the external test and programming controller
module cfgj_jtag_host (
    output logic tck,
    output logic tms,
    output logic tdi,
    input wire logic tdo,
    input wire logic tdo_oe
);
    timeunit 1ns;
    timeprecision 100ps;

    // clock parked low between frames, mode line parked high
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
    end

    // one tck period on the four port signals, tdo taken at the rise
    task automatic step(input logic m, input logic d, output logic o);
        #1;
        tms = m;
        tdi = d;
        #14;
        tck = 1'b1;
        o = tdo;
        #15;
        tck = 1'b0;
    endtask

    // walk the state machine, tms lsb first, unused data line toggling
    task automatic tms_seq(input logic [7:0] m, input int n);
        logic o;
        for (int i = 0; i < n; i++) begin
            step(m[i], ~tdi, o);
        end
    endtask

    // idle to capture, shift n bits, update, back to idle; flash never touched
    task automatic scan(input logic ir, input int n, input logic [191:0] din,
                        output logic [191:0] dout);
        logic o;
        dout = '0;
        tms_seq(ir ? 8'h03 : 8'h01, ir ? 4 : 3);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], o);
            dout[i] = o;
        end
        tms_seq(8'h01, 2);
    endtask
endmodule // cfgj_jtag_host

// file: verification/cfgj_tap_top_bench.sv
// self-checking bench of the configuration device test access port
`include "cfgj_defines.svh"
module cfgj_tap_top_bench;
    timeunit 1ns;
    timeprecision 100ps;
    import cfgj_pkg::*;

    localparam logic [31:0] ID_EXP = 32'h3c96_5a21; // arbitrary value
    logic clk;
    logic rst_n;
    logic tck, tms, tdi, tdo, tdo_oe;
    logic reconf_pin, reconf_drv, reconf_oe, reconf_low;
    logic [`CFGJ_BSR_LEN-1:0] pin_lvl; // levels at the boundary pins
    logic [`CFGJ_DR32_LEN-1:0] usercode_nv; // stored usercode
    cfgj_bs_ctl_t bs_ctl; // boundary drive toward the pins
    int n_errors = 0;
    int compares = 0;
    logic [191:0] din;
    logic [191:0] dout;
    logic [9:0] op;
    int unsigned seed_v;

    // open-drain reconfig wire with pull-up
    assign reconf_pin = reconf_oe ? reconf_drv : 1'b1;

    // system clock, 4 ns
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    cfgj_tap_top #(.ID_VALUE(ID_EXP)) u_cfgj_tap_top (
        .clk(clk), .rst_n(rst_n), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
        .tdo_oe(tdo_oe), .pin_lvl(pin_lvl), .usercode_nv(usercode_nv),
        .bs_ctl(bs_ctl), .reconf_pin(reconf_pin), .reconf_drv(reconf_drv),
        .reconf_oe(reconf_oe), .reconf_low(reconf_low)
    );

    cfgj_jtag_host u_cfgj_jtag_host (
        .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe)
    );

    // six random words
    function automatic logic [191:0] rnd192();
        return {$urandom(), $urandom(), $urandom(), $urandom(), $urandom(), $urandom()};
    endfunction

    // compare of scanned data
    task automatic check_scan(input logic [191:0] got, input logic [191:0] exp);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    // compare of a single pin or flag
    task automatic check_pin(input logic got, input logic exp);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    // counts, verdict and end of run
    task automatic tally_and_finish();
        $display("compares %0d errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // bounded wait for the reconfig drive to reach a level
    task automatic wait_oe(input logic lvl);
        int k;
        k = 0;
        while (reconf_oe !== lvl) begin
            @(posedge clk);
            #1;
            k++;
            if (k > 40) begin
                n_errors++;
                tally_and_finish();
            end
        end
        check_pin(reconf_oe, lvl);
    endtask

    // load an instruction, capture pattern must come out
    task automatic load_ir(input logic [9:0] code);
        u_cfgj_jtag_host.scan(1'b1, 10, {182'h0, code}, dout);
        check_scan(dout, 192'h001);
    endtask

    // one-stage delay path, queue holds the model of the bypass bit
    task automatic bypass_chk(input logic [9:0] code);
        bit q[$];
        logic [191:0] e;
        e = '0;
        q = {1'b0};
        load_ir(code);
        din = rnd192();
        u_cfgj_jtag_host.scan(1'b0, 8, din, dout);
        for (int i = 0; i < 8; i++) begin
            q.push_back(din[i]);
            e[i] = q.pop_front();
        end
        check_scan(dout, e);
    endtask

    // main sequence
    initial begin
        rst_n = 1'b0;
        pin_lvl = '0;
        usercode_nv = '0;
        seed_v = $urandom(91114);
        repeat (3) @(posedge clk);
        #1 rst_n = 1'b1;
        // power-on interval before the first frame
        repeat (10) @(posedge clk);
        u_cfgj_jtag_host.tms_seq(8'h1f, 6);
        // identification as reset default, then selected explicitly
        for (int k = 0; k < 2; k++) begin
            if (k == 1) begin
                load_ir(`CFGJ_OP_IDCODE);
            end
            u_cfgj_jtag_host.scan(1'b0, 32, rnd192(), dout);
            check_scan(dout, {160'h0, ID_EXP});
        end
        // stored usercode, changed ahead of the instruction load
        @(posedge clk);
        #1 usercode_nv = $urandom();
        load_ir(`CFGJ_OP_USERCODE);
        u_cfgj_jtag_host.scan(1'b0, 32, rnd192(), dout);
        check_scan(dout, {160'h0, usercode_nv});
        // twenty bits through the instruction path show its length
        din = {172'h0, `CFGJ_OP_BYPASS, 10'h2a5};
        u_cfgj_jtag_host.scan(1'b1, 20, din, dout);
        check_scan(dout, {172'h0, 10'h2a5, 10'h001});
        bypass_chk(`CFGJ_OP_BYPASS);
        // park in the data shift state, output enable must be on
        u_cfgj_jtag_host.tms_seq(8'h01, 3);
        #1;
        check_pin(tdo_oe, 1'b1);
        u_cfgj_jtag_host.tms_seq(8'h03, 3);
        // unassigned opcodes fall back to the bypass bit
        for (int k = 0; k < 4; k++) begin
            do op = 10'($urandom()); while (op inside {`CFGJ_OP_SAMPLE, `CFGJ_OP_EXTEST,
                `CFGJ_OP_BYPASS, `CFGJ_OP_IDCODE, `CFGJ_OP_USERCODE,
                `CFGJ_OP_INIT_CONFIG, `CFGJ_OP_HOLD_CONFIG_INSTRUCTION});
            bypass_chk(op);
        end
        // sample then extest, with no configuration running
        for (int k = 0; k < 2; k++) begin
            @(posedge clk);
            din = rnd192();
            #1 pin_lvl = din[173:0];
            load_ir(k == 1 ? `CFGJ_OP_EXTEST : `CFGJ_OP_SAMPLE);
            check_pin(bs_ctl.extest, k == 1);
            din = rnd192();
            u_cfgj_jtag_host.scan(1'b0, 174, din, dout);
            check_scan(dout, {18'h0, pin_lvl});
            check_scan({18'h0, bs_ctl.drive}, {18'h0, din[173:0]});
            check_pin(tdo_oe, 1'b0);
        end
        u_cfgj_jtag_host.tms_seq(8'h1f, 6);
        check_pin(bs_ctl.extest, 1'b0);
        // reconfigure pulse while idle, release on leaving idle
        load_ir(`CFGJ_OP_INIT_CONFIG);
        u_cfgj_jtag_host.tms_seq(8'h00, 2);
        wait_oe(1'b1);
        repeat (4) @(posedge clk);
        #1;
        check_pin(reconf_low, 1'b1);
        u_cfgj_jtag_host.tms_seq(8'h03, 2);
        wait_oe(1'b0);
        repeat (4) @(posedge clk);
        #1;
        check_pin(reconf_low, 1'b0);
        check_pin(reconf_drv, 1'b0);
        u_cfgj_jtag_host.tms_seq(8'h01, 2);
        // hold survives scans and logic reset until reconfigure
        load_ir(`CFGJ_OP_HOLD_CONFIG_INSTRUCTION);
        // idle edges carry the hold flag into the drive flag
        u_cfgj_jtag_host.tms_seq(8'h00, 2);
        wait_oe(1'b1);
        u_cfgj_jtag_host.tms_seq(8'h1f, 6);
        bypass_chk(`CFGJ_OP_BYPASS);
        repeat (8) @(posedge clk);
        #1;
        check_pin(reconf_oe, 1'b1);
        load_ir(`CFGJ_OP_INIT_CONFIG);
        u_cfgj_jtag_host.tms_seq(8'h03, 2);
        wait_oe(1'b0);
        tally_and_finish();
    end
endmodule // cfgj_tap_top_bench
